// [design/async_event_counter.sv]
// Asynchronous event counter with APB register access
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module async_event_counter #(
	parameter int TICK_DIV = async_event_counter_pkg::INT_TICK_DIV
) (
	input  wire logic                                       mclk,
	input  wire logic                                       rst_n,
	input  wire logic                                       psel,
	input  wire logic                                       penable,
	input  wire logic                                       pwrite,
	input  wire logic [async_event_counter_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                                pwdata,
	output logic      [31:0]                                prdata,
	output logic                                            pready,
	output logic                                            pslverr,
	input  wire logic                                       event_input_low,
	input  wire logic                                       event_input_high,
	input  wire async_event_counter_pkg::power_mode_t       power_mode,
	output logic                                            irq
);
	import async_event_counter_pkg::*;

	logic [1:0]           sync1_ff;
	logic [1:0]           sync2_ff;
	logic [1:0]           prev_ff;
	logic [7:0]           edge_sel_ff;
	logic [7:0]           clock_ctrl_ff;
	counter_ctrl_status_t ctrl_ff;
	logic [CNT_W-1:0]     cnt_low_ff;
	logic [CNT_W-1:0]     cnt_high_ff;
	logic                 irq_flag_ff;
	logic                 irq_enable_ff;
	logic [31:0]          prdata_ff;
	logic                 pslverr_ff;
	logic [15:0]          tick_cnt_ff;
	logic                 tick;
	logic                 src_low;
	logic                 src_high;
	logic                 low_async;
	logic                 high_async;
	logic                 lp_mode;
	logic                 flag_freeze;
	logic                 run_low;
	logic                 run_high;
	logic                 inc_low;
	logic                 inc_high;
	logic                 low_wrap;
	logic                 high_wrap;
	logic                 wrap16;
	logic                 wr;
	logic                 setup;
	logic [15:0]          idx;
	logic                 mapped;
	logic [7:0]           rd_byte;

	function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
		case (sel)
			EDGE_FALL: edge_hit = prv & ~cur;
			EDGE_RISE: edge_hit = ~prv & cur;
			default:   edge_hit = prv ^ cur;
		endcase
	endfunction

	function automatic logic is_reg(input logic [15:0] a);
		is_reg = (a == IDX_EDGE_SEL) || (a == IDX_CLOCK_CTRL) ||
			(a == IDX_CTRL_STATUS) || (a == IDX_COUNT_HIGH) ||
			(a == IDX_COUNT_LOW) || (a == IDX_IRQ_FLAG) || (a == IDX_IRQ_ENABLE);
	endfunction

	// Pin synchronisers; counting happens on mclk after this
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					sync1_ff[g] <= 1'b0;
					sync2_ff[g] <= 1'b0;
					prev_ff[g]  <= 1'b0;
				end else begin
					sync1_ff[g] <= (g == 0) ? event_input_low : event_input_high;
					sync2_ff[g] <= sync1_ff[g];
					prev_ff[g]  <= sync2_ff[g];
				end
			end
		end
	endgenerate

	// Internal tick for non-pin clock selections
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_ff <= 16'h0000;
		end else if (tick) begin
			tick_cnt_ff <= 16'h0000;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 16'h0001;
		end
	end
	assign tick = (tick_cnt_ff == 16'(TICK_DIV - 1));

	assign low_async  = clock_ctrl_ff[CLKSEL_LOW_POS +: 2] == CLKSEL_ASYNC;
	assign high_async = clock_ctrl_ff[CLKSEL_HIGH_POS +: 2] == CLKSEL_ASYNC;
	assign src_low    = low_async ?
		edge_hit(edge_sel_ff[EDGE_LOW_POS +: 2], sync2_ff[0], prev_ff[0]) : tick;
	assign src_high   = high_async ?
		edge_hit(edge_sel_ff[EDGE_HIGH_POS +: 2], sync2_ff[1], prev_ff[1]) : tick;

	assign lp_mode     = (power_mode == MODE_WATCH) || (power_mode == MODE_SUBACT) ||
		(power_mode == MODE_SUBSLP) || (power_mode == MODE_STANDBY);
	assign flag_freeze = (power_mode == MODE_WATCH) || (power_mode == MODE_STANDBY);
	assign run_low     = !lp_mode || low_async;
	assign run_high    = !lp_mode || (ctrl_ff.channel_split ? high_async : low_async);

	assign inc_low   = src_low && ctrl_ff.count_enable_low && ctrl_ff.counter_release_low &&
		run_low;
	assign low_wrap  = inc_low && (cnt_low_ff == COUNT_MAX);
	assign inc_high  = ctrl_ff.count_enable_high && ctrl_ff.counter_release_high && run_high &&
		(ctrl_ff.channel_split ? src_high : low_wrap);
	assign high_wrap = inc_high && (cnt_high_ff == COUNT_MAX);
	assign wrap16    = !ctrl_ff.channel_split && high_wrap;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_low_ff <= COUNT_RST;
		end else if (!ctrl_ff.counter_release_low) begin
			cnt_low_ff <= COUNT_RST;
		end else if (inc_low) begin
			cnt_low_ff <= cnt_low_ff + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_high_ff <= COUNT_RST;
		end else if (!ctrl_ff.counter_release_high) begin
			cnt_high_ff <= COUNT_RST;
		end else if (inc_high) begin
			cnt_high_ff <= cnt_high_ff + 8'h01;
		end
	end

	// APB slave, zero wait states
	assign setup  = psel && !penable;
	assign wr     = psel && penable && pwrite;
	assign idx    = paddr[ADDR_W-1:2];
	assign mapped = is_reg(idx) && (paddr[1:0] == 2'b00);
	assign pready = 1'b1;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			edge_sel_ff   <= EDGE_SEL_RST;
			clock_ctrl_ff <= CLOCK_CTRL_RST;
			irq_enable_ff <= 1'b0;
		end else if (wr && mapped) begin
			if (idx == IDX_EDGE_SEL) begin
				edge_sel_ff <= pwdata[7:0];
			end
			if (idx == IDX_CLOCK_CTRL) begin
				clock_ctrl_ff <= pwdata[7:0];
			end
			if (idx == IDX_IRQ_ENABLE) begin
				irq_enable_ff <= pwdata[0];
			end
		end
	end

	// Control bits, overflow flags; hardware set beats software clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= counter_ctrl_status_t'(CTRL_STATUS_RST);
		end else begin
			if (wr && mapped && idx == IDX_CTRL_STATUS) begin
				ctrl_ff.channel_split        <= pwdata[4];
				ctrl_ff.count_enable_high    <= pwdata[3];
				ctrl_ff.count_enable_low     <= pwdata[2];
				ctrl_ff.counter_release_high <= pwdata[1];
				ctrl_ff.counter_release_low  <= pwdata[0];
				ctrl_ff.overflow_flag_high   <= ctrl_ff.overflow_flag_high & pwdata[7];
				ctrl_ff.overflow_flag_low    <= ctrl_ff.overflow_flag_low & pwdata[6];
			end
			if (high_wrap && !flag_freeze) begin
				ctrl_ff.overflow_flag_high <= 1'b1;
			end
			if (ctrl_ff.channel_split && low_wrap && !flag_freeze) begin
				ctrl_ff.overflow_flag_low <= 1'b1;
			end
		end
	end

	// Interrupt flag stays set until software writes zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_flag_ff <= 1'b0;
		end else if (wrap16) begin
			irq_flag_ff <= 1'b1;
		end else if (wr && mapped && idx == IDX_IRQ_FLAG && !pwdata[0]) begin
			irq_flag_ff <= 1'b0;
		end
	end

	assign irq = irq_flag_ff && irq_enable_ff;

	always_comb begin
		case (idx)
			IDX_EDGE_SEL:    rd_byte = edge_sel_ff;
			IDX_CLOCK_CTRL:  rd_byte = clock_ctrl_ff;
			IDX_CTRL_STATUS: rd_byte = ctrl_ff & 8'hEF | {3'b000, ctrl_ff.channel_split, 4'h0};
			IDX_COUNT_HIGH:  rd_byte = cnt_high_ff;
			IDX_COUNT_LOW:   rd_byte = cnt_low_ff;
			IDX_IRQ_FLAG:    rd_byte = {7'h00, irq_flag_ff};
			IDX_IRQ_ENABLE:  rd_byte = {7'h00, irq_enable_ff};
			default:         rd_byte = 8'h00;
		endcase
	end

	// Read data and error captured in the setup cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (setup) begin
			prdata_ff  <= (mapped && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
			pslverr_ff <= !mapped;
		end
	end
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	split_reset_a: assert property (@(posedge mclk) disable iff (1'b0)
		!rst_n |=> !ctrl_ff.channel_split)
		else $error("channel split not cleared by reset");

	low_count_a: assert property (
		inc_low && cnt_low_ff != COUNT_MAX |=> cnt_low_ff == $past(cnt_low_ff) + 8'h01)
		else $error("low counter missed an event");

	wrap16_a: assert property (
		wrap16 && !flag_freeze |=> cnt_low_ff == 8'h00 && cnt_high_ff == 8'h00 &&
			ctrl_ff.overflow_flag_high)
		else $error("16-bit overflow did not wrap and flag");

	irq_flag_a: assert property (
		wrap16 |=> irq_flag_ff)
		else $error("overflow did not set interrupt flag");

	irq_out_a: assert property (
		wrap16 && irq_enable_ff && !(wr && idx == IDX_IRQ_ENABLE) |=> irq)
		else $error("interrupt not raised");

	high_cascade_a: assert property (
		!ctrl_ff.channel_split && !inc_high ##0 !ctrl_ff.channel_split [*2]
			|-> $stable(cnt_high_ff) || !ctrl_ff.counter_release_high)
		else $error("high counter moved without low overflow");

	flag_freeze_a: assert property (
		flag_freeze && !wr |=> !$rose(ctrl_ff.overflow_flag_high) &&
			!$rose(ctrl_ff.overflow_flag_low))
		else $error("overflow flag changed in watch or standby");

	lp_hold_a: assert property (
		lp_mode && !low_async && ctrl_ff.counter_release_low |=> $stable(cnt_low_ff))
		else $error("low counter ran in low-power mode");

	enable_gate_a: assert property (
		!ctrl_ff.count_enable_low && ctrl_ff.counter_release_low |=> $stable(cnt_low_ff))
		else $error("low counter counted while disabled");

	release_hold_a: assert property (
		!ctrl_ff.counter_release_high |=> cnt_high_ff == 8'h00)
		else $error("high counter not held in reset");

	flag_sticky_a: assert property (
		irq_flag_ff && !(wr && idx == IDX_IRQ_FLAG) |=> irq_flag_ff)
		else $error("interrupt flag cleared by itself");

	high_count_a: assert property (
		!ctrl_ff.channel_split && low_wrap && ctrl_ff.count_enable_high &&
			ctrl_ff.counter_release_high && cnt_high_ff != COUNT_MAX
			|=> cnt_high_ff == $past(cnt_high_ff) + 8'h01)
		else $error("high counter missed a low overflow");

	low_wrap_a: assert property (
		low_wrap |=> cnt_low_ff == 8'h00)
		else $error("low counter did not wrap to zero");

	split_high_a: assert property (
		ctrl_ff.channel_split && src_high && ctrl_ff.count_enable_high &&
			ctrl_ff.counter_release_high && run_high && cnt_high_ff != COUNT_MAX
			|=> cnt_high_ff == $past(cnt_high_ff) + 8'h01)
		else $error("split high counter missed an event");

	split_isolate_a: assert property (
		ctrl_ff.channel_split && !src_high && ctrl_ff.counter_release_high
			|=> $stable(cnt_high_ff))
		else $error("split high counter moved without its own event");

	low_flag_split_a: assert property (
		ctrl_ff.channel_split && low_wrap && !flag_freeze |=> ctrl_ff.overflow_flag_low)
		else $error("low overflow flag not set in split mode");

	low_flag_16bit_a: assert property (
		!ctrl_ff.channel_split && !ctrl_ff.overflow_flag_low |=> !ctrl_ff.overflow_flag_low)
		else $error("low overflow flag set in 16-bit mode");

	edge_rise_a: assert property (
		low_async && edge_sel_ff[EDGE_LOW_POS +: 2] == EDGE_RISE && $rose(sync2_ff[0])
			|-> src_low)
		else $error("rising edge not counted");

	edge_fall_a: assert property (
		low_async && edge_sel_ff[EDGE_LOW_POS +: 2] == EDGE_FALL && $fell(sync2_ff[0])
			|-> src_low)
		else $error("falling edge not counted");

	edge_both_a: assert property (
		low_async && edge_sel_ff[EDGE_LOW_POS +: 2] == EDGE_BOTH && $changed(sync2_ff[0])
			|-> src_low)
		else $error("edge not counted in both-edge mode");

	edge_ignore_a: assert property (
		low_async && edge_sel_ff[EDGE_LOW_POS +: 2] == EDGE_RISE && !$rose(sync2_ff[0])
			|-> !src_low)
		else $error("event counted on the wrong edge");

	irq_clear_a: assert property (
		irq_flag_ff && !wrap16 && wr && mapped && idx == IDX_IRQ_FLAG && !pwdata[0]
			|=> !irq_flag_ff)
		else $error("interrupt flag not cleared by writing zero");

	irq_mask_a: assert property (
		wr && mapped && idx == IDX_IRQ_ENABLE && !pwdata[0] |=> !irq)
		else $error("interrupt raised while disabled");

	flag_keep_a: assert property (
		ctrl_ff.overflow_flag_high && !(wr && idx == IDX_CTRL_STATUS)
			|=> ctrl_ff.overflow_flag_high)
		else $error("high overflow flag cleared by itself");

	flag_clear_a: assert property (
		wr && mapped && idx == IDX_CTRL_STATUS && !pwdata[7] && !(high_wrap && !flag_freeze)
			|=> !ctrl_ff.overflow_flag_high)
		else $error("high overflow flag not cleared by writing zero");

	release_low_a: assert property (
		!ctrl_ff.counter_release_low |=> cnt_low_ff == 8'h00)
		else $error("low counter not held in reset");

	enable_high_a: assert property (
		!ctrl_ff.count_enable_high && ctrl_ff.counter_release_high |=> $stable(cnt_high_ff))
		else $error("high counter counted while disabled");

	lp_high_hold_a: assert property (
		lp_mode && !ctrl_ff.channel_split && !low_async && ctrl_ff.counter_release_high
			|=> $stable(cnt_high_ff))
		else $error("high counter ran in low-power mode");

	freeze_count_a: assert property (
		flag_freeze && low_async && src_low && ctrl_ff.count_enable_low &&
			ctrl_ff.counter_release_low |-> inc_low)
		else $error("counting stopped in watch or standby");

endmodule

// [design/async_event_counter_pkg.sv]
// Constants and types for the asynchronous event counter
package async_event_counter_pkg;

	localparam int          ADDR_W          = 18;
	localparam int          CNT_W           = 8;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_EDGE_SEL    = 16'hFF92;
	localparam logic [15:0] IDX_CLOCK_CTRL  = 16'hFF94;
	localparam logic [15:0] IDX_CTRL_STATUS = 16'hFF95;
	localparam logic [15:0] IDX_COUNT_HIGH  = 16'hFF96;
	localparam logic [15:0] IDX_COUNT_LOW   = 16'hFF97;
	localparam logic [15:0] IDX_IRQ_FLAG    = 16'hFF98;
	localparam logic [15:0] IDX_IRQ_ENABLE  = 16'hFF99;
	// Field positions
	localparam int          EDGE_LOW_POS    = 4;
	localparam int          EDGE_HIGH_POS   = 2;
	localparam int          CLKSEL_LOW_POS  = 4;
	localparam int          CLKSEL_HIGH_POS = 6;
	// Reset values, counter maximum and pin clock selection code
	localparam logic [7:0]  EDGE_SEL_RST    = 8'h00;
	localparam logic [7:0]  CLOCK_CTRL_RST  = 8'h00;
	localparam logic [7:0]  CTRL_STATUS_RST = 8'h00;
	localparam logic [7:0]  COUNT_RST       = 8'h00;
	localparam logic [7:0]  COUNT_MAX       = 8'hFF;
	localparam logic [1:0]  CLKSEL_ASYNC    = 2'h0;
	// Internal tick period in mclk cycles for non-pin sources
	localparam int          INT_TICK_DIV    = 16;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_BOTH = 2'b10
	} edge_sel_t;

	typedef enum logic [2:0] {
		MODE_ACTIVE  = 3'b000,
		MODE_SLEEP   = 3'b001,
		MODE_WATCH   = 3'b010,
		MODE_SUBACT  = 3'b011,
		MODE_SUBSLP  = 3'b100,
		MODE_STANDBY = 3'b101
	} power_mode_t;

	typedef struct packed {
		logic overflow_flag_high;
		logic overflow_flag_low;
		logic rsvd;
		logic channel_split;
		logic count_enable_high;
		logic count_enable_low;
		logic counter_release_high;
		logic counter_release_low;
	} counter_ctrl_status_t;

endpackage

// [dv/event_source.sv]
// Event pulse source driving the counter pins
`timescale 1ns/1ps
module event_source (
	input  wire logic mclk,
	output logic      pin_low,
	output logic      pin_high
);
	initial begin
		pin_low = 1'b0;
		pin_high = 1'b0;
	end
	// Pins idle low; each level held three cycles
	task automatic pulse(input logic lo, input logic hi, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			pin_low <= lo;
			pin_high <= hi;
			repeat (3) @(posedge mclk);
			pin_low <= 1'b0;
			pin_high <= 1'b0;
			repeat (2) @(posedge mclk);
		end
		repeat (6) @(posedge mclk);
	endtask
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the event counter
`timescale 1ns/1ps
module tb_top;
	import async_event_counter_pkg::*;
	logic              mclk, rst_n, psel, penable, pwrite, ev_lo, ev_hi;
	logic              pready, pslverr, irq, rerr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rdat;
	power_mode_t       power_mode;
	int                err_count, total_checks, cyc;

	async_event_counter #(.TICK_DIV(4)) dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .event_input_low(ev_lo),
		.event_input_high(ev_hi), .power_mode(power_mode), .irq(irq));
	event_source src_u (.mclk(mclk), .pin_low(ev_lo), .pin_high(ev_hi));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rd(input string what, input logic [15:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(what, {24'h000000, exp}, rdat);
	endtask

	task automatic chk_irq(input logic exp);
		@(posedge mclk);
		#1;
		chk("irq", {31'h0, exp}, {31'h0, irq});
	endtask

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		power_mode = MODE_ACTIVE;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		rd("ctrl_status", IDX_CTRL_STATUS, CTRL_STATUS_RST);
		rd("count_high", IDX_COUNT_HIGH, COUNT_RST);
		rd("count_low", IDX_COUNT_LOW, COUNT_RST);
		rd("edge_sel", IDX_EDGE_SEL, EDGE_SEL_RST);
		rd("unmapped", 16'hFF93, 8'h00);
		chk("pslverr", 32'h1, {31'h0, rerr});
		chk_irq(1'b0);
		$display("test reset done");
		for (int c = 0; c < 3; c++) begin
			wr(IDX_EDGE_SEL, 8'(c << 4));
			wr(IDX_CTRL_STATUS, 8'h00);
			wr(IDX_CTRL_STATUS, 8'h0F);
			src_u.pulse(1'b1, 1'b0, 3);
			wr(IDX_CTRL_STATUS, 8'h03);
			rd("count_low", IDX_COUNT_LOW, (c == 2) ? 8'h06 : 8'h03);
		end
		src_u.pulse(1'b1, 1'b0, 2);
		rd("count_low", IDX_COUNT_LOW, 8'h06);
		wr(IDX_CTRL_STATUS, 8'h00);
		rd("count_low", IDX_COUNT_LOW, 8'h00);
		$display("test edges done");
		wr(IDX_CTRL_STATUS, 8'h0F);
		src_u.pulse(1'b1, 1'b0, 128);
		wr(IDX_CTRL_STATUS, 8'h03);
		rd("count_high", IDX_COUNT_HIGH, 8'h01);
		rd("ctrl_status", IDX_CTRL_STATUS, 8'h03);
		wr(IDX_CTRL_STATUS, 8'h0F);
		power_mode <= MODE_WATCH;
		src_u.pulse(1'b1, 1'b0, 1);
		power_mode <= MODE_ACTIVE;
		wr(IDX_CTRL_STATUS, 8'h03);
		rd("count_low", IDX_COUNT_LOW, 8'h02);
		power_mode <= MODE_SUBACT;
		wr(IDX_CLOCK_CTRL, 8'h10);
		wr(IDX_CTRL_STATUS, 8'h00);
		wr(IDX_CTRL_STATUS, 8'h0F);
		repeat (40) @(posedge mclk);
		wr(IDX_CTRL_STATUS, 8'h03);
		rd("count_low", IDX_COUNT_LOW, 8'h00);
		power_mode <= MODE_ACTIVE;
		wr(IDX_CLOCK_CTRL, 8'h00);
		$display("test modes done");
		wr(IDX_CTRL_STATUS, 8'h00);
		wr(IDX_EDGE_SEL, 8'h14);
		wr(IDX_CTRL_STATUS, 8'h1F);
		src_u.pulse(1'b1, 1'b1, 255);
		wr(IDX_CTRL_STATUS, 8'h13);
		rd("count_high", IDX_COUNT_HIGH, COUNT_MAX);
		rd("count_low", IDX_COUNT_LOW, COUNT_MAX);
		wr(IDX_CTRL_STATUS, 8'h1F);
		power_mode <= MODE_WATCH;
		src_u.pulse(1'b1, 1'b1, 1);
		power_mode <= MODE_ACTIVE;
		wr(IDX_CTRL_STATUS, 8'h13);
		rd("ctrl_status", IDX_CTRL_STATUS, 8'h13);
		rd("count_high", IDX_COUNT_HIGH, 8'h00);
		wr(IDX_CTRL_STATUS, 8'h1F);
		src_u.pulse(1'b1, 1'b1, 255);
		wr(IDX_CTRL_STATUS, 8'h13);
		rd("count_low", IDX_COUNT_LOW, COUNT_MAX);
		wr(IDX_CTRL_STATUS, 8'h0F);
		wr(IDX_IRQ_ENABLE, 8'h01);
		chk_irq(1'b0);
		src_u.pulse(1'b1, 1'b0, 1);
		chk_irq(1'b1);
		wr(IDX_CTRL_STATUS, 8'h83);
		rd("ctrl_status", IDX_CTRL_STATUS, 8'h83);
		rd("count_high", IDX_COUNT_HIGH, 8'h00);
		rd("count_low", IDX_COUNT_LOW, 8'h00);
		rd("irq_flag", IDX_IRQ_FLAG, 8'h01);
		wr(IDX_IRQ_ENABLE, 8'h00);
		chk_irq(1'b0);
		wr(IDX_IRQ_FLAG, 8'h01);
		rd("irq_flag", IDX_IRQ_FLAG, 8'h01);
		wr(IDX_IRQ_FLAG, 8'h00);
		rd("irq_flag", IDX_IRQ_FLAG, 8'h00);
		wr(IDX_IRQ_ENABLE, 8'h01);
		chk_irq(1'b0);
		$display("test overflow done");
		results();
	end
endmodule
